// file: verilog/dcm_pkg.sv
package dcm_pkg;
	localparam int          DCM_NBYTES      = 6;
	localparam int          DCM_NLINES      = 48;
	localparam int          DCM_NMON        = 15;
	localparam int          DCM_NSTAT       = 2;
	localparam int          DCM_IDN_MAX     = 72;
	localparam int          DCM_XLAT_LEN    = 16;
	localparam int          DCM_CLK_HZ      = 25000000;
	localparam int          DCM_PW_MIN_MS   = 10;
	localparam int          DCM_PW_MAX_MS   = 30000;
	localparam logic [14:0] DCM_PW_DEF_MS   = 15'h0032;
	localparam int          DCM_STB_US      = 5;
	localparam int          DCM_CYC_PER_MS  = DCM_CLK_HZ / 1000;
	localparam int          DCM_STB_CYC     = (DCM_STB_US * DCM_CLK_HZ + 999999) / 1000000;
	// register word addresses
	localparam logic [7:0]  A_OUT0          = 8'h00;
	localparam logic [7:0]  A_IN0           = 8'h08;
	localparam logic [7:0]  A_OPOL0         = 8'h10;
	localparam logic [7:0]  A_IPOL0         = 8'h18;
	localparam logic [7:0]  A_BITCMD        = 8'h20;
	localparam logic [7:0]  A_PW            = 8'h21;
	localparam logic [7:0]  A_STRCFG        = 8'h22;
	localparam logic [7:0]  A_CTLPOL        = 8'h23;
	localparam logic [7:0]  A_FMT           = 8'h24;
	localparam logic [7:0]  A_LOCK          = 8'h25;
	localparam logic [7:0]  A_DEFAULTS      = 8'h26;
	localparam logic [7:0]  A_STROBE        = 8'h27;
	localparam logic [7:0]  A_QCOND         = 8'h30;
	localparam logic [7:0]  A_QEVENT        = 8'h31;
	localparam logic [7:0]  A_QENAB         = 8'h32;
	localparam logic [7:0]  A_QPTR          = 8'h33;
	localparam logic [7:0]  A_QNTR          = 8'h34;
	localparam logic [7:0]  A_OCOND         = 8'h38;
	localparam logic [7:0]  A_OEVENT        = 8'h39;
	localparam logic [7:0]  A_OENAB         = 8'h3A;
	localparam logic [7:0]  A_OPTR          = 8'h3B;
	localparam logic [7:0]  A_ONTR          = 8'h3C;
	localparam logic [7:0]  A_XLAT0         = 8'h40;
	localparam logic [7:0]  A_IDN0          = 8'h80;
	// bit command field: [7:5] byte, [4:2] bit, [1:0] op
	localparam logic [1:0]  BOP_SET         = 2'h1;
	localparam logic [1:0]  BOP_CLR         = 2'h2;
	localparam logic [1:0]  BOP_PULSE       = 2'h3;
	// defaults
	localparam logic [14:0] DEF_QPTR        = 15'h7FFF;
	localparam logic [14:0] DEF_QNTR        = 15'h0000;
	localparam logic [6:0]  DEF_CTLPOL      = 7'h00;
	localparam logic [31:0] DEF_STRCFG      = 32'h0000_0000;
	localparam logic [7:0]  DEF_FMT         = 8'h00;
endpackage : dcm_pkg

// file: verilog/dcm_top.sv
// Local design decisions: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module dcm_top
	import dcm_pkg::*;
#(
	parameter int CYC_PER_MS = DCM_CYC_PER_MS
) (
	input  wire logic                  i_clk,
	input  wire logic                  i_rst,
	input  wire logic [7:0]            i_addr,
	input  wire logic [31:0]           i_wdata,
	input  wire logic                  i_wr,
	input  wire logic                  i_rd,
	output logic      [31:0]           o_rdata,
	input  wire logic [DCM_NLINES-1:0] i_lines,
	input  wire logic [DCM_NSTAT-1:0]  i_status,
	output logic      [DCM_NLINES-1:0] o_lines,
	output logic      [DCM_NLINES-1:0] o_lines_oe,
	output logic                       o_data_strobe,
	output logic      [6:0]            o_ctl_pol,
	output logic      [7:0]            o_format,
	output logic                       o_srq
);
	typedef struct packed {
		logic [DCM_NLINES-1:0] out;
		logic [DCM_NLINES-1:0] oe;
		logic [DCM_NLINES-1:0] opol;
		logic [DCM_NLINES-1:0] ipol;
		logic [DCM_NLINES-1:0] pulse;
		logic [31:0]           pms_cnt;
		logic [14:0]           pw;
		logic [14:0]           pw_left;
		logic [31:0]           strcfg;
		logic [6:0]            ctlpol;
		logic [7:0]            fmt;
		logic                  lock;
		logic [7:0]            stb_cnt;
		logic [DCM_NMON-1:0]   qprev;
		logic [DCM_NMON-1:0]   qev;
		logic [DCM_NMON-1:0]   qen;
		logic [DCM_NMON-1:0]   qptr;
		logic [DCM_NMON-1:0]   qntr;
		logic [DCM_NSTAT-1:0]  oprev;
		logic [DCM_NSTAT-1:0]  oev;
		logic [DCM_NSTAT-1:0]  oen;
		logic [DCM_NSTAT-1:0]  optr;
		logic [DCM_NSTAT-1:0]  ontr;
		logic [31:0]           rdata;
		logic                  srq;
		logic                  primed;
	} dcm_state_t;

	dcm_state_t st_reg;
	dcm_state_t st_next;
	logic [7:0] xlat_mem [DCM_XLAT_LEN];
	logic [7:0] idn_mem  [DCM_IDN_MAX];
	logic       cfg_ok;
	logic [2:0] bsel;
	logic [5:0] bitidx;

	function automatic logic [7:0] dcm_byte(input logic [DCM_NLINES-1:0] v, input logic [2:0] b);
		dcm_byte = v[b*8 +: 8];
	endfunction : dcm_byte

	function automatic logic in_range(input logic [7:0] a, input logic [7:0] base, input int n);
		in_range = (a >= base) && (int'(a) < int'(base) + n);
	endfunction : in_range

	assign cfg_ok = !st_reg.lock;
	assign bsel   = i_addr[2:0];
	assign bitidx = 6'(i_wdata[7:5] * 8 + i_wdata[4:2]);

	// translation table and identification text, writes gated by lock
	always_ff @(posedge i_clk) begin
		if (i_wr && cfg_ok && in_range(i_addr, A_XLAT0, DCM_XLAT_LEN)) begin
			xlat_mem[4'(i_addr - A_XLAT0)] <= i_wdata[7:0];
		end
		if (i_wr && cfg_ok && in_range(i_addr, A_IDN0, DCM_IDN_MAX)) begin
			idn_mem[7'(i_addr - A_IDN0)] <= i_wdata[7:0];
		end
	end

	always_comb begin
		logic [DCM_NMON-1:0]  qcur;
		logic [DCM_NMON-1:0]  qhit;
		logic [DCM_NSTAT-1:0] ohit;
		qcur = i_lines[DCM_NMON-1:0];
		qhit = (qcur & ~st_reg.qprev & st_reg.qptr) | (~qcur & st_reg.qprev & st_reg.qntr);
		ohit = (i_status & ~st_reg.oprev & st_reg.optr) | (~i_status & st_reg.oprev & st_reg.ontr);
		// no history right after reset: lines idling high on pull-ups must not look like edges
		qhit = qhit & {DCM_NMON{st_reg.primed}};
		ohit = ohit & {DCM_NSTAT{st_reg.primed}};
		st_next = st_reg;
		st_next.rdata = 32'h0000_0000;
		st_next.primed = 1'b1;
		st_next.qprev = qcur;
		st_next.oprev = i_status;
		// pulse timing in ms ticks
		if (st_reg.pulse != '0) begin
			if (st_reg.pms_cnt >= 32'(CYC_PER_MS - 1)) begin
				st_next.pms_cnt = 32'h0000_0000;
				if (st_reg.pw_left <= 15'h0001) begin
					st_next.out   = st_reg.out ^ st_reg.pulse;
					st_next.pulse = '0;
				end else begin
					st_next.pw_left = st_reg.pw_left - 15'h0001;
				end
			end else begin
				st_next.pms_cnt = st_reg.pms_cnt + 32'h0000_0001;
			end
		end
		if (st_reg.stb_cnt != 8'h00) begin
			st_next.stb_cnt = st_reg.stb_cnt - 8'h01;
		end
		if (i_rd) begin
			if (in_range(i_addr, A_OUT0, DCM_NBYTES)) begin
				st_next.rdata = {24'h000000, dcm_byte(st_reg.out ^ st_reg.opol, bsel)};
			end else if (in_range(i_addr, A_IN0, DCM_NBYTES)) begin
				st_next.rdata = {24'h000000, dcm_byte(i_lines ^ st_reg.ipol, bsel)};
			end else if (in_range(i_addr, A_OPOL0, DCM_NBYTES)) begin
				st_next.rdata = {24'h000000, dcm_byte(st_reg.opol, bsel)};
			end else if (in_range(i_addr, A_IPOL0, DCM_NBYTES)) begin
				st_next.rdata = {24'h000000, dcm_byte(st_reg.ipol, bsel)};
			end else if (in_range(i_addr, A_XLAT0, DCM_XLAT_LEN)) begin
				st_next.rdata = {24'h000000, xlat_mem[4'(i_addr - A_XLAT0)]};
			end else if (in_range(i_addr, A_IDN0, DCM_IDN_MAX)) begin
				st_next.rdata = {24'h000000, idn_mem[7'(i_addr - A_IDN0)]};
			end else begin
				unique case (i_addr)
					A_PW:     st_next.rdata = {17'h00000, st_reg.pw};
					A_STRCFG: st_next.rdata = st_reg.strcfg;
					A_CTLPOL: st_next.rdata = {25'h0000000, st_reg.ctlpol};
					A_FMT:    st_next.rdata = {24'h000000, st_reg.fmt};
					A_LOCK:   st_next.rdata = {31'h00000000, st_reg.lock};
					A_QCOND:  st_next.rdata = {17'h00000, qcur};
					A_QEVENT: st_next.rdata = {17'h00000, st_reg.qev};
					A_QENAB:  st_next.rdata = {17'h00000, st_reg.qen};
					A_QPTR:   st_next.rdata = {17'h00000, st_reg.qptr};
					A_QNTR:   st_next.rdata = {17'h00000, st_reg.qntr};
					A_OCOND:  st_next.rdata = {30'h00000000, i_status};
					A_OEVENT: st_next.rdata = {30'h00000000, st_reg.oev};
					A_OENAB:  st_next.rdata = {30'h00000000, st_reg.oen};
					A_OPTR:   st_next.rdata = {30'h00000000, st_reg.optr};
					A_ONTR:   st_next.rdata = {30'h00000000, st_reg.ontr};
					default:  st_next.rdata = 32'h0000_0000;
				endcase
			end
			// read clears events, new edge wins
			if (i_addr == A_QEVENT) begin
				st_next.qev = '0;
			end
			if (i_addr == A_OEVENT) begin
				st_next.oev = '0;
			end
		end
		if (i_wr) begin
			if (in_range(i_addr, A_OUT0, DCM_NBYTES)) begin
				// output mask on byte write; byte becomes output
				st_next.out[bsel*8 +: 8] = i_wdata[7:0] ^ st_reg.opol[bsel*8 +: 8];
				st_next.oe[bsel*8 +: 8]  = 8'hFF;
			end else if (in_range(i_addr, A_OPOL0, DCM_NBYTES)) begin
				st_next.opol[bsel*8 +: 8] = i_wdata[7:0];
			end else if (in_range(i_addr, A_IPOL0, DCM_NBYTES)) begin
				st_next.ipol[bsel*8 +: 8] = i_wdata[7:0];
			end else if (i_addr == A_BITCMD && i_wdata[7:5] < 3'(DCM_NBYTES)) begin
				// single bit set, clear or pulse
				st_next.oe[bitidx] = 1'b1;
				unique case (i_wdata[1:0])
					BOP_SET:   st_next.out[bitidx] = 1'b1;
					BOP_CLR:   st_next.out[bitidx] = 1'b0;
					BOP_PULSE: begin
						if (!st_reg.pulse[bitidx]) begin
							st_next.out[bitidx]   = ~st_reg.out[bitidx];
							st_next.pulse[bitidx] = 1'b1;
						end
						st_next.pw_left = st_reg.pw;
						st_next.pms_cnt = 32'h0000_0000;
					end
					default: ;
				endcase
			end else if (i_addr == A_STROBE) begin
				// strobe for DCM_STB_CYC cycles on each write to A_STROBE
				st_next.stb_cnt = 8'(DCM_STB_CYC);
			end else if (i_addr == A_LOCK) begin
				st_next.lock = i_wdata[0];
			end else if (cfg_ok) begin
				unique case (i_addr)
					A_PW: begin
						if (i_wdata >= 32'(DCM_PW_MIN_MS) && i_wdata <= 32'(DCM_PW_MAX_MS)) begin
							st_next.pw = i_wdata[14:0];
						end
					end
					A_STRCFG: st_next.strcfg = i_wdata;
					A_CTLPOL: st_next.ctlpol = i_wdata[6:0];
					A_FMT:    st_next.fmt = i_wdata[7:0];
					A_QENAB:  st_next.qen = i_wdata[DCM_NMON-1:0];
					A_QPTR:   st_next.qptr = i_wdata[DCM_NMON-1:0];
					A_QNTR:   st_next.qntr = i_wdata[DCM_NMON-1:0];
					A_OENAB:  st_next.oen = i_wdata[DCM_NSTAT-1:0];
					A_OPTR:   st_next.optr = i_wdata[DCM_NSTAT-1:0];
					A_ONTR:   st_next.ontr = i_wdata[DCM_NSTAT-1:0];
					A_DEFAULTS: begin
						st_next.pw     = DCM_PW_DEF_MS;
						st_next.strcfg = DEF_STRCFG;
						st_next.ctlpol = DEF_CTLPOL;
						st_next.fmt    = DEF_FMT;
						st_next.opol   = '0;
						st_next.ipol   = '0;
						st_next.qen    = '0;
						st_next.qptr   = DEF_QPTR;
						st_next.qntr   = DEF_QNTR;
						st_next.oen    = '0;
						st_next.optr   = '1;
						st_next.ontr   = '0;
					end
					default: ;
				endcase
			end
		end
		// event record on lines 0-14, set beats clear
		st_next.qev = st_next.qev | qhit;
		st_next.oev = st_next.oev | ohit;
		st_next.srq = |(st_next.qev & st_reg.qen) || |(st_next.oev & st_reg.oen);
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st_reg         <= '0;
			st_reg.pw      <= DCM_PW_DEF_MS;
			st_reg.strcfg  <= DEF_STRCFG;
			st_reg.ctlpol  <= DEF_CTLPOL;
			st_reg.fmt     <= DEF_FMT;
			st_reg.qptr    <= DEF_QPTR;
			st_reg.qntr    <= DEF_QNTR;
			st_reg.optr    <= '1;
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_rdata       = st_reg.rdata;
	assign o_lines       = st_reg.out;
	assign o_lines_oe    = st_reg.oe;
	assign o_data_strobe = (st_reg.stb_cnt != 8'h00);
	assign o_ctl_pol     = st_reg.ctlpol;
	assign o_format      = st_reg.fmt;
	assign o_srq         = st_reg.srq;

	srq_match_a: assert property (@(posedge i_clk) disable iff (i_rst)
		o_srq == (|(st_reg.qev & $past(st_reg.qen)) || |(st_reg.oev & $past(st_reg.oen))))
		else $error("service request mismatch");
	rise_event_a: assert property (@(posedge i_clk) disable iff (i_rst)
		(st_reg.primed && st_reg.qptr[3] && !st_reg.qprev[3] && i_lines[3]) |=> st_reg.qev[3])
		else $error("rising edge not recorded");
	ev_clear_a: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_rd && i_addr == A_QEVENT && i_lines[14:0] == st_reg.qprev) |=> st_reg.qev == '0)
		else $error("event not cleared by read");
	lock_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
		(st_reg.lock && i_wr && i_addr == A_FMT) |=> $stable(st_reg.fmt))
		else $error("locked config changed");
	byte_wr_a: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_wr && i_addr == A_OUT0) |=> o_lines[7:0] == ($past(i_wdata[7:0]) ^ st_reg.opol[7:0]))
		else $error("byte write mask wrong");
	byte_rd_a: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_rd && i_addr == A_IN0) |=> o_rdata[7:0] == ($past(i_lines[7:0]) ^ $past(st_reg.ipol[7:0])))
		else $error("byte read mask wrong");
	bit_set_a: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_wr && i_addr == A_BITCMD && i_wdata[7:0] == 8'h05) |=> o_lines[1] && o_lines_oe[1])
		else $error("bit set failed");
	pw_range_a: assert property (@(posedge i_clk) disable iff (i_rst)
		st_reg.pw >= 15'(DCM_PW_MIN_MS) && st_reg.pw <= 15'(DCM_PW_MAX_MS))
		else $error("pulse width out of range");
	sequence stb_hold_s;
		o_data_strobe [*8] ##1 o_data_strobe;
	endsequence
	stb_len_a: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_wr && i_addr == A_STROBE) |=> stb_hold_s)
		else $error("strobe too short");
	rd_idle_a: assert property (@(posedge i_clk) disable iff (i_rst)
		!i_rd |=> o_rdata == 32'h0000_0000)
		else $error("read data not idle");
	cond_read_a: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_rd && i_addr == A_QCOND) |=> o_rdata == {17'h00000, $past(i_lines[DCM_NMON-1:0])})
		else $error("condition read wrong");
	bit_clr_a: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_wr && i_addr == A_BITCMD && i_wdata[7:0] == 8'h4E) |=> !o_lines[19] && o_lines_oe[19])
		else $error("bit clear failed");
	oe_byte_a: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_wr && i_addr == A_OUT0 + 8'h01) |=> o_lines_oe[15:8] == 8'hFF)
		else $error("byte write left outputs off");
	lock_ctl_a: assert property (@(posedge i_clk) disable iff (i_rst)
		(st_reg.lock && i_wr && i_addr == A_CTLPOL) |=> $stable(o_ctl_pol))
		else $error("locked polarity changed");
	defaults_a: assert property (@(posedge i_clk) disable iff (i_rst)
		(!st_reg.lock && i_wr && i_addr == A_DEFAULTS) |=> st_reg.pw == DCM_PW_DEF_MS && o_ctl_pol == DEF_CTLPOL
		&& st_reg.qptr == DEF_QPTR)
		else $error("defaults not restored");
endmodule : dcm_top

// file: verification/dcm_host_model.sv
`timescale 1ns/1ps
module dcm_host_model (
	input  wire logic        i_clk,
	input  wire logic [31:0] i_rdata,
	output logic      [7:0]  o_addr,
	output logic      [31:0] o_wdata,
	output logic             o_wr,
	output logic             o_rd
);
	initial begin
		o_addr = 8'h00;
		o_wdata = 32'h0000_0000;
		o_wr = 1'b0;
		o_rd = 1'b0;
	end
	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		o_addr  <= a;
		o_wdata <= d;
		o_wr    <= 1'b1;
		@(posedge i_clk);
		o_wr    <= 1'b0;
		// stale data would hide a late capture, so flip it
		o_wdata <= ~d;
	endtask : bus_wr
	task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_rd   <= 1'b1;
		@(posedge i_clk);
		o_rd   <= 1'b0;
		#1;
		d = i_rdata;
	endtask : bus_rd
endmodule : dcm_host_model

// file: verification/test_digital_io_change_monitor.sv
`timescale 1ns/1ps
module test_digital_io_change_monitor
	import dcm_pkg::*;
;
	localparam int CPM = 4;
	logic        i_clk = 1'b0;
	logic        i_rst = 1'b1;
	logic [7:0]  i_addr;
	logic [31:0] i_wdata;
	logic        i_wr;
	logic        i_rd;
	logic [31:0] o_rdata;
	logic [47:0] i_lines = 48'h0;
	logic [1:0]  i_status = 2'h0;
	logic [47:0] o_lines;
	logic [47:0] o_lines_oe;
	logic        o_data_strobe;
	logic [6:0]  o_ctl_pol;
	logic [7:0]  o_format;
	logic        o_srq;
	int          miscompares = 0;
	int          cmp_count = 0;
	always #20 i_clk = ~i_clk;
	dcm_top #(.CYC_PER_MS(CPM)) dcm_top_i (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_lines(i_lines), .i_status(i_status), .o_lines(o_lines),
		.o_lines_oe(o_lines_oe), .o_data_strobe(o_data_strobe), .o_ctl_pol(o_ctl_pol), .o_format(o_format),
		.o_srq(o_srq));
	dcm_host_model dcm_host_model_i (.i_clk(i_clk), .i_rdata(o_rdata), .o_addr(i_addr), .o_wdata(i_wdata),
		.o_wr(i_wr), .o_rd(i_rd));
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		dcm_host_model_i.bus_wr(a, d);
	endtask : wr
	task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] v;
		dcm_host_model_i.bus_rd(a, v);
		chk(nm, v, exp);
	endtask : rdchk
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask : cyc
	task automatic t_reset;
		#1;
		chk("oe_lo", o_lines_oe[31:0], 32'h0);
		chk("oe_hi", 32'(o_lines_oe[47:32]), 32'h0);
		chk("out_lo", o_lines[31:0], 32'h0);
		chk("out_hi", 32'(o_lines[47:32]), 32'h0);
		chk("srq", 32'(o_srq), 32'h0);
		chk("stb", 32'(o_data_strobe), 32'h0);
		chk("fmt", 32'(o_format), 32'h0);
		chk("ctlpol", 32'(o_ctl_pol), 32'h0);
		rdchk("pw", A_PW, 32'h32);
		rdchk("qptr", A_QPTR, 32'h7FFF);
		rdchk("qevent", A_QEVENT, 32'h0);
		rdchk("lock", A_LOCK, 32'h0);
		rdchk("unmapped", 8'hFF, 32'h0);
		$display("test reset done");
	endtask : t_reset
	task automatic t_byte;
		wr(A_OPOL0 + 8'h01, 32'h0F);
		wr(A_OUT0 + 8'h01, 32'hA5);
		wr(A_OUT0, 32'h3C);
		cyc(1);
		chk("out1", 32'(o_lines[15:8]), 32'hAA);
		chk("oe1", 32'(o_lines_oe[15:8]), 32'hFF);
		chk("out0", 32'(o_lines[7:0]), 32'h3C);
		rdchk("opol1", A_OPOL0 + 8'h01, 32'h0F);
		rdchk("out1_rd", A_OUT0 + 8'h01, 32'hA5);
		@(posedge i_clk);
		i_lines[47:40] <= 8'h3C;
		wr(A_IPOL0 + 8'h05, 32'hF0);
		wr(A_IPOL0, 32'h81);
		cyc(4);
		rdchk("in5", A_IN0 + 8'h05, 32'hCC);
		rdchk("in0", A_IN0, 32'h81);
		$display("test byte done");
	endtask : t_byte
	task automatic t_bit;
		logic [47:0] snap;
		wr(A_BITCMD, 32'({3'h2, 3'h3, BOP_SET}));
		wr(A_BITCMD, 32'({3'h0, 3'h1, BOP_SET}));
		cyc(1);
		chk("set", 32'(o_lines[23:16]), 32'h08);
		chk("set_oe", 32'(o_lines_oe[19]), 32'h1);
		chk("set_b0", 32'(o_lines[7:0]), 32'h3E);
		wr(A_BITCMD, 32'({3'h2, 3'h3, BOP_CLR}));
		cyc(1);
		chk("clr", 32'(o_lines[23:16]), 32'h00);
		snap = o_lines;
		wr(A_BITCMD, 32'({3'h6, 3'h0, BOP_SET}));
		cyc(1);
		chk("bad_lo", o_lines[31:0] ^ snap[31:0], 32'h0);
		chk("bad_hi", 32'(o_lines[47:32] ^ snap[47:32]), 32'h0);
		wr(A_PW, 32'h9);
		rdchk("pw_low", A_PW, 32'h32);
		wr(A_PW, 32'h7531);
		rdchk("pw_high", A_PW, 32'h32);
		wr(A_PW, 32'hA);
		rdchk("pw_min", A_PW, 32'hA);
		wr(A_BITCMD, 32'({3'h0, 3'h0, BOP_PULSE}));
		cyc(1);
		chk("pulse_on", 32'(o_lines[0]), 32'h1);
		chk("pulse_rest", 32'(o_lines[7:1]), 32'h1F);
		cyc(10 * CPM - 2);
		chk("pulse_hold", 32'(o_lines[0]), 32'h1);
		cyc(1);
		chk("pulse_end", 32'(o_lines[0]), 32'h0);
		$display("test bit done");
	endtask : t_bit
	task automatic t_mon;
		wr(A_QENAB, 32'h8);
		@(posedge i_clk);
		i_lines[3] <= 1'b1;
		cyc(5);
		chk("srq_rise", 32'(o_srq), 32'h1);
		rdchk("qcond", A_QCOND, 32'h8);
		rdchk("qevent", A_QEVENT, 32'h8);
		cyc(2);
		chk("srq_drop", 32'(o_srq), 32'h0);
		rdchk("qevent_clr", A_QEVENT, 32'h0);
		wr(A_QENAB, 32'h7FFF);
		@(posedge i_clk);
		i_lines[15] <= 1'b1;
		cyc(5);
		chk("srq_l15", 32'(o_srq), 32'h0);
		rdchk("qevent_l15", A_QEVENT, 32'h0);
		wr(A_QPTR, 32'h0);
		wr(A_QNTR, 32'h8);
		@(posedge i_clk);
		i_lines[3] <= 1'b0;
		cyc(5);
		chk("srq_fall", 32'(o_srq), 32'h1);
		rdchk("qevent_fall", A_QEVENT, 32'h8);
		@(posedge i_clk);
		i_lines[3] <= 1'b1;
		cyc(5);
		rdchk("qevent_norise", A_QEVENT, 32'h0);
		wr(A_QPTR, 32'h8);
		@(posedge i_clk);
		i_lines[3] <= 1'b0;
		cyc(5);
		rdchk("qevent_both_f", A_QEVENT, 32'h8);
		@(posedge i_clk);
		i_lines[3] <= 1'b1;
		cyc(5);
		rdchk("qevent_both_r", A_QEVENT, 32'h8);
		$display("test monitor done");
	endtask : t_mon
	task automatic t_oper;
		wr(A_OENAB, 32'h1);
		@(posedge i_clk);
		i_status[0] <= 1'b1;
		cyc(5);
		chk("srq_stat", 32'(o_srq), 32'h1);
		rdchk("ocond", A_OCOND, 32'h1);
		rdchk("oevent", A_OEVENT, 32'h1);
		cyc(2);
		chk("srq_stat_drop", 32'(o_srq), 32'h0);
		@(posedge i_clk);
		i_status[0] <= 1'b0;
		cyc(5);
		chk("srq_stat_fall", 32'(o_srq), 32'h0);
		rdchk("oevent_fall", A_OEVENT, 32'h0);
		$display("test oper done");
	endtask : t_oper
	task automatic t_cfg;
		int n;
		wr(A_CTLPOL, 32'h55);
		wr(A_FMT, 32'h03);
		wr(A_STRCFG, 32'h1234_5678);
		wr(A_XLAT0 + 8'h0F, 32'h41);
		wr(A_IDN0 + 8'h47, 32'h5A);
		cyc(1);
		chk("ctlpol", 32'(o_ctl_pol), 32'h55);
		chk("fmt", 32'(o_format), 32'h03);
		rdchk("strcfg", A_STRCFG, 32'h1234_5678);
		rdchk("ctl_rd", A_CTLPOL, 32'h55);
		rdchk("xlat", A_XLAT0 + 8'h0F, 32'h41);
		rdchk("idn", A_IDN0 + 8'h47, 32'h5A);
		wr(A_LOCK, 32'h1);
		wr(A_CTLPOL, 32'h2A);
		wr(A_FMT, 32'hAA);
		wr(A_XLAT0 + 8'h0F, 32'h42);
		wr(A_DEFAULTS, 32'h1);
		cyc(1);
		chk("locked", 32'(o_ctl_pol), 32'h55);
		chk("locked_fmt", 32'(o_format), 32'h03);
		rdchk("locked_xlat", A_XLAT0 + 8'h0F, 32'h41);
		rdchk("lock_rd", A_LOCK, 32'h1);
		wr(A_LOCK, 32'h0);
		wr(A_DEFAULTS, 32'h1);
		cyc(1);
		chk("def_ctl", 32'(o_ctl_pol), 32'h0);
		chk("def_fmt", 32'(o_format), 32'h0);
		rdchk("def_pw", A_PW, 32'h32);
		rdchk("def_strcfg", A_STRCFG, 32'h0);
		rdchk("def_qptr", A_QPTR, 32'h7FFF);
		wr(A_STROBE, 32'h1);
		#1;
		n = 0;
		while (o_data_strobe === 1'b1 && n < 300) begin
			cyc(1);
			n++;
		end
		chk("stb_len", 32'(n), 32'(DCM_STB_CYC));
		$display("test config done");
	endtask : t_cfg
	task automatic final_report;
		$display("checks %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : final_report
	// generous span: the tests need well under 2000 cycles
	initial begin
		#(40 * 20000);
		miscompares++;
		final_report();
	end
	initial begin
		repeat (8) @(posedge i_clk);
		i_rst <= 1'b0;
		t_reset();
		t_byte();
		t_bit();
		t_mon();
		t_oper();
		t_cfg();
		final_report();
	end
endmodule : test_digital_io_change_monitor
